// [pfdc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pfdc_host_model (
  input wire logic clk_i,
  input wire logic wr_ready_i,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i,
  output logic wr_valid_o,
  output logic [7:0] wr_data_o,
  output logic rd_ready_o
);
  // no cipher in this host, so oversize packets stay legal
  initial begin
    wr_valid_o = 1'b0;
    wr_data_o = 8'h00;
    rd_ready_o = 1'b0;
  end
  // address and length bytes go in like any payload byte
  task automatic push(input logic [7:0] b);
    @(negedge clk_i);
    wr_valid_o = 1'b1;
    wr_data_o = b;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk_i);
      if (wr_ready_i === 1'b1) break;
    end
    @(negedge clk_i);
    wr_valid_o = 1'b0;
    wr_data_o = ~b;
  endtask : push
  // reads only while the fifo shows data
  task automatic pull(output logic [7:0] b);
    b = 8'hxx;
    @(negedge clk_i);
    rd_ready_o = 1'b1;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk_i);
      if (rd_valid_i === 1'b1) begin
        b = rd_data_i;
        break;
      end
    end
    @(negedge clk_i);
    rd_ready_o = 1'b0;
  endtask : pull
endmodule : pfdc_host_model
`default_nettype wire

// [pfdc_pkg.sv]
package pfdc_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_SYNC, TX_PAY, TX_CRC, TX_DONE} pfdc_tx_e;
  typedef enum logic [2:0] {RX_HUNT, RX_PAY, RX_CRC, RX_HOLD} pfdc_rx_e;
endpackage : pfdc_pkg

// [pfdc_regs.svh]
`ifndef PFDC_REGS_SVH
`define PFDC_REGS_SVH
`define PFDC_FIFO_DEPTH 66
`define PFDC_FIFO_WIDTH 8
`define PFDC_CRC_POLY 16'h1021
`define PFDC_CRC_SEED 16'h1d0f
`define PFDC_WHT_SEED 9'h1ff
`define PFDC_ADDR_NODE 2'h1
`define PFDC_ADDR_BCAST 2'h2
`define PFDC_DCF_MANCH 2'h1
`define PFDC_DCF_WHITE 2'h2
`define PFDC_LEN_NOCHECK 8'hff
`endif

// [pfdc_top.sv]
// What this block and its host must do
// RQ1 - host prefills fifo until level or full flag rises
// RQ2 - host refills during transmit whenever level or nonempty flag drops
// RQ3 - packet sent flag rises only after last chip has gone out
// RQ4 - host drains fifo while nonempty until payload ready or crc pass
// RQ5 - leftover fifo bytes stay readable in receive or idle
// RQ6 - host keeps encryption off for packets larger than the fifo
// RQ7 - one sync word setting drives both sending and matching
// RQ8 - packets without the sync word vanish without any flag
// RQ9 - sync detection starts payload reception and sets match flag
// RQ10 - host never programs a sync byte of zero
// RQ11 - selector 01 keeps only packets addressed to node id
// RQ12 - selector 10 keeps packets addressed to node or broadcast id
// RQ13 - address byte stays in fifo, checked in receive after sync only
// RQ14 - transmitting host writes the address byte as ordinary payload
// RQ15 - sync and address match share one flag
// RQ16 - variable length byte must be below maximum, 255 disables check
// RQ17 - crc appended on transmit, recomputed and compared on receive
// RQ18 - crc failure clears fifo silently, or keeps it with payload ready
// RQ19 - received crc bytes never enter the fifo
// RQ20 - crc poly 0x1021, msb first, ccitt seed, inverted output
// RQ21 - host enables at most one dc-free method
// RQ22 - manchester sends one as chips 10, zero as chips 01
// RQ23 - coding covers payload and crc only, sync stays nrz
// RQ24 - whitening xors payload and crc with 9-bit lfsr x^9+x^5+1
// RQ25 - whitening lfsr starts all ones at each payload
`timescale 1ns/1ps
`default_nettype none
`include "pfdc_regs.svh"

module pfdc_fifo #(
  parameter int WIDTH = `PFDC_FIFO_WIDTH,
  parameter int DEPTH = `PFDC_FIFO_DEPTH,
  parameter int LW = $clog2(DEPTH + 1)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [LW-1:0] level_o,
  output logic full_o
);
  if (DEPTH < 2) begin : bad_depth_g
    $error("fifo depth below two");
  end
  // shift style: head always sits in mem_r[0], so the read data is a flop
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [LW-1:0] cnt_r;
  logic [LW-1:0] cnt_nxt;
  logic full_r;
  logic nonempty_r;
  wire push = in_valid_i && !full_r;
  wire pop = out_ready_i && nonempty_r;
  assign cnt_nxt = clr_i ? '0 : LW'(cnt_r + LW'(push) - LW'(pop));
  assign in_ready_o = !full_r;
  assign out_valid_o = nonempty_r;
  assign out_data_o = mem_r[0];
  assign level_o = cnt_r;
  assign full_o = full_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      full_r <= 1'b0;
      nonempty_r <= 1'b0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
      full_r <= cnt_nxt == LW'(DEPTH);
      nonempty_r <= cnt_nxt != '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (pop) begin
          if (push && LW'(i) == LW'(cnt_r - LW'(1)))
            mem_r[i] <= in_data_i;
          else if (i < DEPTH - 1)
            mem_r[i] <= mem_r[(i < DEPTH - 1) ? i + 1 : i];
        end else if (push && LW'(i) == cnt_r) begin
          mem_r[i] <= in_data_i;
        end
      end
    end
  end
endmodule : pfdc_fifo

module pfdc_top #(
  parameter int DEPTH = `PFDC_FIFO_DEPTH,
  parameter int LW = $clog2(DEPTH + 1)
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic MODE_TX_I,
  input wire logic MODE_RX_I,
  input wire logic [63:0] SYNC_WORD_BYTES_I,
  input wire logic [2:0] SYNC_LEN_I,
  input wire logic VAR_LEN_I,
  input wire logic [7:0] MAX_PAYLOAD_LEN_I,
  input wire logic [1:0] ADDR_FILTER_SEL_I,
  input wire logic [7:0] NODE_ID_I,
  input wire logic [7:0] BROADCAST_ID_I,
  input wire logic CRC_ENABLE_I,
  input wire logic KEEP_ON_CRC_FAIL_I,
  input wire logic [1:0] DC_FREE_SEL_I,
  input wire logic [LW-1:0] FIFO_THRESH_I,
  input wire logic HOST_WR_VALID_I,
  input wire logic [7:0] HOST_WR_DATA_I,
  output logic HOST_WR_READY_O,
  output logic HOST_RD_VALID_O,
  output logic [7:0] HOST_RD_DATA_O,
  input wire logic HOST_RD_READY_I,
  input wire logic TX_CHIP_READY_I,
  output logic TX_CHIP_O,
  output logic TX_ACTIVE_O,
  input wire logic RX_CHIP_VALID_I,
  input wire logic RX_CHIP_I,
  output logic PACKET_SENT_FLAG_O,
  output logic PAYLOAD_READY_FLAG_O,
  output logic CRC_PASS_FLAG_O,
  output logic SYNC_ADDR_MATCH_FLAG_O,
  output logic FIFO_LEVEL_FLAG_O,
  output logic FIFO_FULL_FLAG_O,
  output logic FIFO_NONEMPTY_FLAG_O
);
  if (DEPTH < 2 || DEPTH > 255) begin : bad_depth_g
    $error("fifo depth out of range");
  end

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `PFDC_CRC_POLY : 16'h0000); // RQ20
  endfunction : crc_step

  function automatic logic [8:0] wht_step(input logic [8:0] s);
    wht_step = {s[0] ^ s[5], s[8:1]}; // RQ24
  endfunction : wht_step

  function automatic logic [7:0] sync_byte(input logic [63:0] w, input logic [2:0] i);
    sync_byte = w[8'(63 - 8 * i) -: 8];
  endfunction : sync_byte

  // fifo wiring: receive owns the write side, transmit owns the read side
  logic push_r;
  logic [7:0] push_data_r;
  logic clr_r;
  logic tx_pop;
  logic f_in_ready;
  logic f_out_valid;
  logic [7:0] f_out_data;
  logic [LW-1:0] f_level;
  logic f_full;
  wire f_in_valid = MODE_RX_I ? push_r : HOST_WR_VALID_I;
  wire [7:0] f_in_data = MODE_RX_I ? push_data_r : HOST_WR_DATA_I;
  wire f_out_ready = MODE_TX_I ? tx_pop : HOST_RD_READY_I; // RQ5

  pfdc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .LW(LW)) u_fifo (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .clr_i(clr_r),
    .in_valid_i(f_in_valid),
    .in_data_i(f_in_data),
    .in_ready_o(f_in_ready),
    .out_valid_o(f_out_valid),
    .out_data_o(f_out_data),
    .out_ready_i(f_out_ready),
    .level_o(f_level),
    .full_o(f_full)
  );

  assign HOST_WR_READY_O = f_in_ready && !MODE_RX_I;
  assign HOST_RD_VALID_O = f_out_valid && !MODE_TX_I;
  assign HOST_RD_DATA_O = f_out_data;
  assign FIFO_FULL_FLAG_O = f_full;
  assign FIFO_NONEMPTY_FLAG_O = f_out_valid;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I)
      FIFO_LEVEL_FLAG_O <= 1'b0;
    else if (CE_I)
      FIFO_LEVEL_FLAG_O <= f_level > FIFO_THRESH_I;
  end

  // transmit path
  pfdc_pkg::pfdc_tx_e tx_st_r;
  logic [7:0] tx_byte_r;
  logic [2:0] tx_bit_r;
  logic tx_half_r;
  logic [2:0] tx_sidx_r;
  logic [7:0] tx_rem_r;
  logic tx_crclo_r;
  logic [15:0] tx_crc_r;
  logic [8:0] tx_wht_r;
  wire tx_coded = tx_st_r == pfdc_pkg::TX_PAY || tx_st_r == pfdc_pkg::TX_CRC; // RQ23
  wire tx_man = tx_coded && DC_FREE_SEL_I == `PFDC_DCF_MANCH;
  wire tx_wh = tx_coded && DC_FREE_SEL_I == `PFDC_DCF_WHITE;
  wire tx_run = CE_I && TX_CHIP_READY_I && (tx_st_r == pfdc_pkg::TX_SYNC || tx_coded);
  wire tx_bitw = tx_byte_r[7] ^ (tx_wht_r[0] & tx_wh); // RQ24
  wire tx_chip = (tx_man && tx_half_r) ? ~tx_bitw : tx_bitw; // RQ22
  wire tx_bit_end = !tx_man || tx_half_r;
  wire tx_byte_end = tx_run && tx_bit_end && tx_bit_r == 3'h7;
  wire [15:0] tx_crc_nxt = crc_step(tx_crc_r, tx_byte_r[7]);
  wire [7:0] tx_head = f_out_valid ? f_out_data : 8'h00;
  wire tx_last_sync = tx_sidx_r == SYNC_LEN_I;
  assign tx_pop = tx_byte_end && ((tx_st_r == pfdc_pkg::TX_SYNC && tx_last_sync) ||
                  (tx_st_r == pfdc_pkg::TX_PAY && tx_rem_r != 8'h00));

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_st_r <= pfdc_pkg::TX_IDLE;
      tx_byte_r <= 8'h00;
      tx_bit_r <= 3'h0;
      tx_half_r <= 1'b0;
      tx_sidx_r <= 3'h0;
      tx_rem_r <= 8'h00;
      tx_crclo_r <= 1'b0;
      tx_crc_r <= `PFDC_CRC_SEED;
      tx_wht_r <= `PFDC_WHT_SEED;
      TX_CHIP_O <= 1'b0;
      TX_ACTIVE_O <= 1'b0;
      PACKET_SENT_FLAG_O <= 1'b0;
    end else if (CE_I) begin
      if (!MODE_TX_I) begin
        tx_st_r <= pfdc_pkg::TX_IDLE;
        TX_ACTIVE_O <= 1'b0;
        PACKET_SENT_FLAG_O <= 1'b0;
      end else begin
        case (tx_st_r)
          pfdc_pkg::TX_IDLE: begin
            // waits for the first byte so the packet never starts empty
            if (f_out_valid) begin
              tx_st_r <= pfdc_pkg::TX_SYNC;
              tx_byte_r <= sync_byte(SYNC_WORD_BYTES_I, 3'h0); // RQ7
              tx_sidx_r <= 3'h0;
              tx_bit_r <= 3'h0;
              tx_half_r <= 1'b0;
              TX_ACTIVE_O <= 1'b1;
            end
          end
          pfdc_pkg::TX_SYNC, pfdc_pkg::TX_PAY, pfdc_pkg::TX_CRC: begin
            if (tx_run) begin
              TX_CHIP_O <= tx_chip;
              tx_half_r <= tx_man && !tx_half_r;
              if (tx_bit_end) begin
                tx_byte_r <= {tx_byte_r[6:0], 1'b0};
                tx_bit_r <= 3'(tx_bit_r + 3'h1);
                tx_wht_r <= wht_step(tx_wht_r);
                if (tx_st_r == pfdc_pkg::TX_PAY)
                  tx_crc_r <= tx_crc_nxt; // RQ17
              end
            end
            if (tx_byte_end) begin
              case (tx_st_r)
                pfdc_pkg::TX_SYNC: begin
                  if (tx_last_sync) begin
                    tx_st_r <= pfdc_pkg::TX_PAY;
                    tx_byte_r <= tx_head; // RQ14
                    tx_rem_r <= VAR_LEN_I ? tx_head : 8'(MAX_PAYLOAD_LEN_I - 8'h01);
                    tx_crc_r <= `PFDC_CRC_SEED; // RQ20
                    tx_wht_r <= `PFDC_WHT_SEED; // RQ25
                  end else begin
                    tx_sidx_r <= 3'(tx_sidx_r + 3'h1);
                    tx_byte_r <= sync_byte(SYNC_WORD_BYTES_I, 3'(tx_sidx_r + 3'h1));
                  end
                end
                pfdc_pkg::TX_PAY: begin
                  if (tx_rem_r != 8'h00) begin
                    tx_rem_r <= 8'(tx_rem_r - 8'h01);
                    tx_byte_r <= tx_head;
                  end else if (CRC_ENABLE_I) begin
                    tx_st_r <= pfdc_pkg::TX_CRC;
                    tx_byte_r <= ~tx_crc_nxt[15:8]; // RQ17
                    tx_crclo_r <= 1'b0;
                  end else begin
                    tx_st_r <= pfdc_pkg::TX_DONE;
                    PACKET_SENT_FLAG_O <= 1'b1; // RQ3
                  end
                end
                default: begin
                  if (!tx_crclo_r) begin
                    tx_byte_r <= ~tx_crc_r[7:0];
                    tx_crclo_r <= 1'b1;
                  end else begin
                    tx_st_r <= pfdc_pkg::TX_DONE;
                    PACKET_SENT_FLAG_O <= 1'b1; // RQ3
                  end
                end
              endcase
            end
          end
          pfdc_pkg::TX_DONE: TX_ACTIVE_O <= 1'b0;
          default: tx_st_r <= pfdc_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // receive path
  pfdc_pkg::pfdc_rx_e rx_st_r;
  logic [63:0] rx_sh_r;
  logic [7:0] rx_byte_r;
  logic [2:0] rx_bit_r;
  logic rx_half_r;
  logic rx_first_r;
  logic [7:0] rx_idx_r;
  logic [7:0] rx_rem_r;
  logic [7:0] rx_crchi_r;
  logic rx_crclo_r;
  logic [15:0] rx_crc_r;
  logic [8:0] rx_wht_r;
  wire rx_in = CE_I && MODE_RX_I && RX_CHIP_VALID_I;
  wire [63:0] rx_sh_nxt = {rx_sh_r[62:0], RX_CHIP_I};
  wire [6:0] rx_nbits = 7'({SYNC_LEN_I, 3'h0}) + 7'h08;
  wire [63:0] rx_mask = ~64'h0 << 7'(7'd64 - rx_nbits);
  wire rx_sync_hit = ((rx_sh_nxt << 7'(7'd64 - rx_nbits)) & rx_mask) ==
                     (SYNC_WORD_BYTES_I & rx_mask); // RQ7
  wire rx_coded = rx_st_r == pfdc_pkg::RX_PAY || rx_st_r == pfdc_pkg::RX_CRC;
  wire rx_man = DC_FREE_SEL_I == `PFDC_DCF_MANCH;
  wire rx_wh = DC_FREE_SEL_I == `PFDC_DCF_WHITE;
  // manchester takes the first chip of each pair as the bit: 10 is one, 01 is zero
  wire rx_raw = rx_man ? rx_first_r : RX_CHIP_I; // RQ22
  wire rx_bit_end = rx_in && rx_coded && (!rx_man || rx_half_r);
  wire rx_d = rx_raw ^ (rx_wht_r[0] & rx_wh); // RQ24
  wire [7:0] rx_byte_nxt = {rx_byte_r[6:0], rx_d};
  wire rx_byte_end = rx_bit_end && rx_bit_r == 3'h7;
  wire [15:0] rx_crc_nxt = crc_step(rx_crc_r, rx_d);
  wire rx_len_byte = VAR_LEN_I && rx_idx_r == 8'h00;
  wire rx_len_bad = rx_len_byte && MAX_PAYLOAD_LEN_I != `PFDC_LEN_NOCHECK &&
                    rx_byte_nxt >= MAX_PAYLOAD_LEN_I; // RQ16
  wire rx_addr_byte = rx_idx_r == (VAR_LEN_I ? 8'h01 : 8'h00);
  wire rx_node_hit = rx_byte_nxt == NODE_ID_I;
  wire rx_bcast_hit = rx_byte_nxt == BROADCAST_ID_I;
  wire rx_addr_bad = rx_addr_byte && ((ADDR_FILTER_SEL_I == `PFDC_ADDR_NODE && !rx_node_hit) ||
                     (ADDR_FILTER_SEL_I == `PFDC_ADDR_BCAST && !rx_node_hit && !rx_bcast_hit));
  wire [7:0] rx_rem_cur = (rx_idx_r != 8'h00) ? rx_rem_r :
                          VAR_LEN_I ? rx_byte_nxt : 8'(MAX_PAYLOAD_LEN_I - 8'h01);
  wire rx_crc_ok = {rx_crchi_r, rx_byte_nxt} == ~rx_crc_r;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_st_r <= pfdc_pkg::RX_HUNT;
      rx_sh_r <= 64'h0;
      rx_byte_r <= 8'h00;
      rx_bit_r <= 3'h0;
      rx_half_r <= 1'b0;
      rx_first_r <= 1'b0;
      rx_idx_r <= 8'h00;
      rx_rem_r <= 8'h00;
      rx_crchi_r <= 8'h00;
      rx_crclo_r <= 1'b0;
      rx_crc_r <= `PFDC_CRC_SEED;
      rx_wht_r <= `PFDC_WHT_SEED;
      push_r <= 1'b0;
      push_data_r <= 8'h00;
      clr_r <= 1'b0;
      SYNC_ADDR_MATCH_FLAG_O <= 1'b0;
      PAYLOAD_READY_FLAG_O <= 1'b0;
      CRC_PASS_FLAG_O <= 1'b0;
    end else if (CE_I) begin
      push_r <= 1'b0;
      clr_r <= 1'b0;
      // a flag set in this cycle overrides the drain-clear below
      // a push still in flight keeps the flag, else a one-byte packet loses it
      if (!f_out_valid && !push_r)
        PAYLOAD_READY_FLAG_O <= 1'b0;
      if (!MODE_RX_I) begin
        rx_st_r <= pfdc_pkg::RX_HUNT;
        SYNC_ADDR_MATCH_FLAG_O <= 1'b0;
      end else if (rx_in) begin
        case (rx_st_r)
          pfdc_pkg::RX_HUNT: begin
            rx_sh_r <= rx_sh_nxt; // RQ8
            if (rx_sync_hit) begin
              rx_st_r <= pfdc_pkg::RX_PAY; // RQ9
              SYNC_ADDR_MATCH_FLAG_O <= 1'b1; // RQ15
              CRC_PASS_FLAG_O <= 1'b0;
              rx_idx_r <= 8'h00;
              rx_bit_r <= 3'h0;
              rx_half_r <= 1'b0;
              rx_crclo_r <= 1'b0;
              rx_crc_r <= `PFDC_CRC_SEED;
              rx_wht_r <= `PFDC_WHT_SEED; // RQ25
              rx_sh_r <= 64'h0;
            end
          end
          pfdc_pkg::RX_PAY, pfdc_pkg::RX_CRC: begin
            if (rx_man && !rx_half_r) begin
              rx_first_r <= RX_CHIP_I;
              rx_half_r <= 1'b1;
            end else begin
              rx_half_r <= 1'b0;
              rx_byte_r <= rx_byte_nxt;
              rx_bit_r <= 3'(rx_bit_r + 3'h1);
              rx_wht_r <= wht_step(rx_wht_r);
              if (rx_st_r == pfdc_pkg::RX_PAY)
                rx_crc_r <= rx_crc_nxt; // RQ17
            end
            if (rx_byte_end && rx_st_r == pfdc_pkg::RX_PAY) begin
              if (rx_len_bad || rx_addr_bad) begin
                // drop the whole packet: earlier bytes are already queued
                rx_st_r <= pfdc_pkg::RX_HUNT; // RQ11 RQ12
                clr_r <= 1'b1;
                SYNC_ADDR_MATCH_FLAG_O <= 1'b0;
              end else begin
                push_r <= 1'b1; // RQ13
                push_data_r <= rx_byte_nxt;
                rx_idx_r <= 8'(rx_idx_r + 8'h01);
                rx_rem_r <= 8'(rx_rem_cur - 8'h01);
                if (rx_rem_cur == 8'h00) begin
                  if (CRC_ENABLE_I) begin
                    rx_st_r <= pfdc_pkg::RX_CRC;
                  end else begin
                    rx_st_r <= pfdc_pkg::RX_HOLD;
                    PAYLOAD_READY_FLAG_O <= 1'b1;
                  end
                end
              end
            end
            if (rx_byte_end && rx_st_r == pfdc_pkg::RX_CRC) begin
              // checksum bytes are compared here and never queued
              if (!rx_crclo_r) begin
                rx_crchi_r <= rx_byte_nxt; // RQ19
                rx_crclo_r <= 1'b1;
              end else if (rx_crc_ok) begin
                rx_st_r <= pfdc_pkg::RX_HOLD;
                PAYLOAD_READY_FLAG_O <= 1'b1; // RQ17
                CRC_PASS_FLAG_O <= 1'b1;
              end else if (KEEP_ON_CRC_FAIL_I) begin
                rx_st_r <= pfdc_pkg::RX_HOLD;
                PAYLOAD_READY_FLAG_O <= 1'b1; // RQ18
              end else begin
                rx_st_r <= pfdc_pkg::RX_HUNT; // RQ18
                clr_r <= 1'b1;
                SYNC_ADDR_MATCH_FLAG_O <= 1'b0;
              end
            end
          end
          pfdc_pkg::RX_HOLD: rx_st_r <= pfdc_pkg::RX_HOLD;
          default: rx_st_r <= pfdc_pkg::RX_HUNT;
        endcase
      end
    end
  end
endmodule : pfdc_top
`default_nettype wire

// [pfdc_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
module pfdc_top_props #(
  parameter int DEPTH = 66
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic MODE_TX_I,
  input wire logic MODE_RX_I,
  input wire logic TX_CHIP_READY_I,
  input wire logic HOST_WR_READY_O,
  input wire logic HOST_RD_VALID_O,
  input wire logic TX_CHIP_O,
  input wire logic TX_ACTIVE_O,
  input wire logic PACKET_SENT_FLAG_O,
  input wire logic PAYLOAD_READY_FLAG_O,
  input wire logic CRC_PASS_FLAG_O,
  input wire logic SYNC_ADDR_MATCH_FLAG_O,
  input wire logic FIFO_FULL_FLAG_O,
  input wire logic FIFO_NONEMPTY_FLAG_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  a_sent_on_chip: assert property ($rose(PACKET_SENT_FLAG_O) |-> $past(TX_CHIP_READY_I) && TX_ACTIVE_O)
    else $error("packet sent flag rose without a final chip");
  a_sent_holds: assert property (PACKET_SENT_FLAG_O && MODE_TX_I |=> PACKET_SENT_FLAG_O)
    else $error("packet sent flag dropped in transmit");
  a_sent_clears: assert property (!MODE_TX_I |=> !PACKET_SENT_FLAG_O)
    else $error("packet sent flag outside transmit");
  // the first chip may be loaded as the packet starts, before any pulse
  a_chip_on_pulse: assert property ($changed(TX_CHIP_O) |-> $past(TX_CHIP_READY_I) || !$past(TX_ACTIVE_O))
    else $error("chip changed without a pulse");
  a_active_in_tx: assert property ($rose(TX_ACTIVE_O) |-> $past(MODE_TX_I))
    else $error("packet started outside transmit");
  a_match_in_rx: assert property ($rose(SYNC_ADDR_MATCH_FLAG_O) |-> $past(MODE_RX_I))
    else $error("match flag outside receive");
  a_crc_with_ready: assert property ($rose(CRC_PASS_FLAG_O) |-> PAYLOAD_READY_FLAG_O)
    else $error("crc pass without payload ready");
  a_ready_has_data: assert property ($rose(PAYLOAD_READY_FLAG_O) |-> FIFO_NONEMPTY_FLAG_O)
    else $error("payload ready with empty fifo");
  a_wr_gate: assert property (HOST_WR_READY_O |-> !MODE_RX_I && !FIFO_FULL_FLAG_O)
    else $error("write ready while full or receiving");
  a_rd_gate: assert property (HOST_RD_VALID_O |-> !MODE_TX_I && FIFO_NONEMPTY_FLAG_O)
    else $error("read valid while empty or sending");
  c_sent: cover property ($rose(PACKET_SENT_FLAG_O));
  c_crc_pass: cover property ($rose(CRC_PASS_FLAG_O));
  c_kept_bad: cover property ($rose(PAYLOAD_READY_FLAG_O) && !CRC_PASS_FLAG_O);
endmodule : pfdc_top_props
bind pfdc_top pfdc_top_props #(.DEPTH(DEPTH)) u_props (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .MODE_TX_I(MODE_TX_I), .MODE_RX_I(MODE_RX_I),
  .TX_CHIP_READY_I(TX_CHIP_READY_I), .HOST_WR_READY_O(HOST_WR_READY_O),
  .HOST_RD_VALID_O(HOST_RD_VALID_O), .TX_CHIP_O(TX_CHIP_O), .TX_ACTIVE_O(TX_ACTIVE_O),
  .PACKET_SENT_FLAG_O(PACKET_SENT_FLAG_O), .PAYLOAD_READY_FLAG_O(PAYLOAD_READY_FLAG_O),
  .CRC_PASS_FLAG_O(CRC_PASS_FLAG_O), .SYNC_ADDR_MATCH_FLAG_O(SYNC_ADDR_MATCH_FLAG_O),
  .FIFO_FULL_FLAG_O(FIFO_FULL_FLAG_O), .FIFO_NONEMPTY_FLAG_O(FIFO_NONEMPTY_FLAG_O));
`default_nettype wire

// [tb_packet_filter_dc_free_sel_coder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pfdc_regs.svh"
module tb_packet_filter_dc_free_sel_coder;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mtx = 1'b0, mrx = 1'b0, vlen = 1'b0, crc_en = 1'b1, keep = 1'b0;
  logic crdy = 1'b0, rxv = 1'b0, rxc = 1'b0;
  logic [1:0] sel = 2'h0, dcf = 2'h0, rxdc = 2'h0;
  logic ce = 1'b1;
  logic [7:0] maxlen = 8'h02;
  logic [6:0] thr = 7'h01;
  logic wv, wr, rv, rr, txc, txa, f_sent, f_prdy, f_crc, f_match, f_lvl, f_full, f_ne;
  logic [7:0] wd, rd;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  // sync bytes are both nonzero
  localparam logic [15:0] SYNC = 16'ha596;
  initial forever #12.5 clk = ~clk;
  pfdc_top DUT (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce), .MODE_TX_I(mtx), .MODE_RX_I(mrx),
    .SYNC_WORD_BYTES_I({SYNC, 48'h0}), .SYNC_LEN_I(3'h1), .VAR_LEN_I(vlen),
    .MAX_PAYLOAD_LEN_I(maxlen), .ADDR_FILTER_SEL_I(sel), .NODE_ID_I(8'h12),
    .BROADCAST_ID_I(8'h34), .CRC_ENABLE_I(crc_en), .KEEP_ON_CRC_FAIL_I(keep),
    .DC_FREE_SEL_I(dcf), .FIFO_THRESH_I(thr), .HOST_WR_VALID_I(wv), .HOST_WR_DATA_I(wd),
    .HOST_WR_READY_O(wr), .HOST_RD_VALID_O(rv), .HOST_RD_DATA_O(rd), .HOST_RD_READY_I(rr),
    .TX_CHIP_READY_I(crdy), .TX_CHIP_O(txc), .TX_ACTIVE_O(txa), .RX_CHIP_VALID_I(rxv),
    .RX_CHIP_I(rxc), .PACKET_SENT_FLAG_O(f_sent), .PAYLOAD_READY_FLAG_O(f_prdy),
    .CRC_PASS_FLAG_O(f_crc), .SYNC_ADDR_MATCH_FLAG_O(f_match), .FIFO_LEVEL_FLAG_O(f_lvl),
    .FIFO_FULL_FLAG_O(f_full), .FIFO_NONEMPTY_FLAG_O(f_ne));
  pfdc_host_model host (.clk_i(clk), .wr_ready_i(wr), .rd_valid_i(rv), .rd_data_i(rd),
    .wr_valid_o(wv), .wr_data_o(wd), .rd_ready_o(rr));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  function automatic logic [15:0] crc2(input logic [15:0] d);
    logic [15:0] c;
    c = `PFDC_CRC_SEED;
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `PFDC_CRC_POLY : 16'h0);
    return ~c;
  endfunction : crc2
  // idle chips carry the inverse so a stale value never looks valid
  task automatic send_bits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk);
      rxv = 1'b1;
      rxc = v[i];
      @(negedge clk);
      rxv = 1'b0;
      rxc = ~v[i];
    end
  endtask : send_bits
  // a pull while frozen must not pop, so the drain below starts at byte zero
  task automatic fill_case;
    logic [7:0] b;
    thr = 7'h40;
    for (int i = 0; i < `PFDC_FIFO_DEPTH; i++) host.push(8'(i));
    repeat (2) @(negedge clk);
    chk(f_full, 1'b1);
    chk(wr, 1'b0);
    chk(f_lvl, 1'b1);
    ce = 1'b0;
    host.pull(b);
    ce = 1'b1;
    chk(b, 8'h00);
    chk(f_full, 1'b1);
    for (int i = 0; i < `PFDC_FIFO_DEPTH; i++) begin
      host.pull(b);
      chk(b, 8'(i));
    end
    repeat (2) @(negedge clk);
    chk(f_ne, 1'b0);
    $display("fill case done");
  endtask : fill_case
  task automatic tx_case(input logic [1:0] dc);
    logic e[$];
    logic [8:0] w;
    logic [31:0] pk;
    logic b;
    dcf = dc;
    vlen = 1'b0;
    maxlen = 8'h02;
    thr = 7'h01;
    host.push(8'h3c);
    host.push(8'hc1);
    repeat (2) @(negedge clk);
    chk(f_lvl, 1'b1);
    for (int i = 15; i >= 0; i--) e.push_back(SYNC[i]);
    pk = {16'h3cc1, crc2(16'h3cc1)};
    w = `PFDC_WHT_SEED;
    for (int i = 31; i >= 0; i--) begin
      b = pk[i];
      if (dc == `PFDC_DCF_WHITE) begin
        b = b ^ w[0];
        w = {w[0] ^ w[5], w[8:1]};
      end
      e.push_back(b);
      if (dc == `PFDC_DCF_MANCH) e.push_back(~b);
    end
    mtx = 1'b1;
    repeat (2) @(negedge clk);
    chk(txa, 1'b1);
    foreach (e[i]) begin
      if (i + 1 == e.size()) chk(f_sent, 1'b0);
      crdy = 1'b1;
      @(negedge clk);
      crdy = 1'b0;
      chk(txc, e[i]);
      @(negedge clk);
    end
    chk(f_sent, 1'b1);
    mtx = 1'b0;
    repeat (3) @(negedge clk);
    $display("tx case %0d done", dc);
  endtask : tx_case
  // ex: 0 dropped, 1 accepted with good crc, 2 kept despite bad crc
  task automatic rx_case(input logic vm, input logic [1:0] fs, input logic [7:0] mx,
                         input logic [15:0] pl, input logic [15:0] cx, input logic kp,
                         input logic [1:0] ex);
    logic [7:0] b;
    logic [8:0] w;
    logic [31:0] v;
    dcf = rxdc;
    vlen = vm;
    sel = fs;
    maxlen = mx;
    keep = kp;
    thr = 7'h00;
    mrx = 1'b1;
    send_bits(32'haaaa_00ff, 32);
    chk(f_match, 1'b0);
    send_bits({16'h0, SYNC}, 16);
    repeat (2) @(negedge clk);
    chk(f_match, 1'b1);
    v = {pl, crc2(pl) ^ cx};
    w = `PFDC_WHT_SEED;
    if (rxdc == `PFDC_DCF_WHITE) begin
      for (int i = 31; i >= 0; i--) begin
        v[i] = v[i] ^ w[0];
        w = {w[0] ^ w[5], w[8:1]};
      end
    end
    send_bits(v, 32);
    for (int k = 0; k < 20 && f_prdy !== 1'b1; k++) @(negedge clk);
    chk(f_prdy, ex != 2'h0);
    chk(f_crc, ex == 2'h1);
    chk(f_ne, ex != 2'h0);
    if (ex != 2'h0) begin
      host.pull(b);
      chk(b, pl[15:8]);
      host.pull(b);
      chk(b, pl[7:0]);
      repeat (2) @(negedge clk);
      chk(f_ne, 1'b0);
    end
    mrx = 1'b0;
    repeat (4) @(negedge clk);
    $display("rx case %h done", pl);
  endtask : rx_case
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    fill_case();
    for (int d = 0; d < 3; d++) tx_case(d[1:0]);
    rx_case(1'b0, 2'h0, 8'h02, 16'h1277, 16'h0, 1'b0, 2'h1);
    rx_case(1'b0, `PFDC_ADDR_NODE, 8'h02, 16'h1277, 16'h0, 1'b0, 2'h1);
    rx_case(1'b0, `PFDC_ADDR_NODE, 8'h02, 16'h3477, 16'h0, 1'b0, 2'h0);
    rx_case(1'b0, `PFDC_ADDR_BCAST, 8'h02, 16'h3477, 16'h0, 1'b0, 2'h1);
    rx_case(1'b0, `PFDC_ADDR_BCAST, 8'h02, 16'h5677, 16'h0, 1'b0, 2'h0);
    rx_case(1'b0, 2'h0, 8'h02, 16'h1277, 16'h0100, 1'b0, 2'h0);
    rx_case(1'b0, 2'h0, 8'h02, 16'h1277, 16'h0100, 1'b1, 2'h2);
    crc_en = 1'b0;
    rx_case(1'b0, 2'h0, 8'h02, 16'h1277, 16'h0, 1'b0, 2'h2);
    crc_en = 1'b1;
    rxdc = `PFDC_DCF_WHITE;
    rx_case(1'b0, 2'h0, 8'h02, 16'h1277, 16'h0, 1'b0, 2'h1);
    rxdc = 2'h0;
    rx_case(1'b1, 2'h0, 8'h02, 16'h0177, 16'h0, 1'b0, 2'h1);
    rx_case(1'b1, 2'h0, 8'h01, 16'h0177, 16'h0, 1'b0, 2'h0);
    give_verdict();
  end
endmodule : tb_packet_filter_dc_free_sel_coder
`default_nettype wire
